// *** hdl/adcc_params.svh ***
//------------------------------------------------------------
// Functional notes
// - run enable high runs, low holds reset
// - clearing run enable also resets dividers
// - bit 3 background offset, needs background
// - bit 2 foreground offset, needs foreground
// - bit 1 enables background calibration
// - bit 0 high: clear values, run foreground
// - bit 0 low: clear values, skip foreground
// - idle core field chooses disabled core
// - offset averaging depth at bits 6:4
// - linearity averaging depth at bits 2:0
// - status read-only, code at 4:2
// - stopped flag follows background halt
// - no background: stopped after foreground
// - foreground done flag at bit 0
// - selector drives status output pin
// - trigger source: register or pin
//------------------------------------------------------------
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH

//------------------------------------------------------------
// register offsets
//------------------------------------------------------------
`define ADCC_OFS_RUN_EN   8'h61
`define ADCC_OFS_MODE     8'h62
`define ADCC_OFS_IDLE     8'h64
`define ADCC_OFS_AVG      8'h68
`define ADCC_OFS_STATUS   8'h6A
`define ADCC_OFS_PIN      8'h6B
`define ADCC_OFS_SOFT     8'h6C

//------------------------------------------------------------
// reset values
//------------------------------------------------------------
`define ADCC_RST_RUN_EN   8'h01
`define ADCC_RST_MODE     8'h01
`define ADCC_RST_IDLE     8'h01
`define ADCC_RST_AVG      8'h61
`define ADCC_RST_PIN      8'h00
`define ADCC_RST_SOFT     8'h01

//------------------------------------------------------------
// field positions
//------------------------------------------------------------
`define ADCC_RUN_EN_BIT   0
`define ADCC_BGOS_BIT     3
`define ADCC_FGOS_BIT     2
`define ADCC_BG_BIT       1
`define ADCC_FG_BIT       0
`define ADCC_IDLE_HI      1
`define ADCC_IDLE_LO      0
`define ADCC_OSAVG_HI     6
`define ADCC_OSAVG_LO     4
`define ADCC_LINAVG_HI    2
`define ADCC_LINAVG_LO    0
`define ADCC_STAT_HI      4
`define ADCC_STAT_LO      2
`define ADCC_STOP_BIT     1
`define ADCC_DONE_BIT     0
`define ADCC_PINSEL_HI    2
`define ADCC_PINSEL_LO    1
`define ADCC_TRIGSRC_BIT  0
`define ADCC_SOFT_BIT     0

//------------------------------------------------------------
// encodings and timing
//------------------------------------------------------------
`define ADCC_IDLE_RSVD    2'h3
`define ADCC_PSEL_DONE    2'h0
`define ADCC_PSEL_STOP    2'h1
`define ADCC_PSEL_ALARM   2'h2
`define ADCC_PSEL_LOW     2'h3
`define ADCC_PHASE_BASE   12'h010

`endif

// *** hdl/adcc_pkg.sv ***
`include "adcc_params.svh"

package adcc_pkg;

  //----------------------------------------------------------
  // calibration sequencer states
  //----------------------------------------------------------
  typedef enum logic [2:0] {
    ADCC_HOLD,
    ADCC_CLEAR,
    ADCC_FG_LIN,
    ADCC_FG_OFS,
    ADCC_BG_RUN,
    ADCC_BG_STOP,
    ADCC_DONE
  } adcc_state_t;

  // effective settings handed to the engine
  typedef struct packed {
    logic       bg_offset_cal_enable;
    logic       fg_offset_cal_enable;
    logic       background_cal_enable;
    logic       foreground_cal_enable;
    logic       idle_active;
    logic [1:0] idle_core;
    logic [2:0] offset_averaging_level;
    logic [2:0] linearity_averaging_level;
  } adcc_cfg_t;

  // engine status as seen by software
  typedef struct packed {
    logic [2:0] code;
    logic       stopped;
    logic       foreground_complete_flag;
  } adcc_stat_t;

  // phase length grows with the averaging depth
  function automatic logic [11:0] adcc_phase_len(input logic [2:0] avg);
    adcc_phase_len = `ADCC_PHASE_BASE << avg;
  endfunction : adcc_phase_len

endpackage : adcc_pkg

// *** hdl/adcc_cal_seq.sv ***
`timescale 1ns/1ps

module adcc_cal_seq
  import adcc_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // control
  input  wire logic       run_en_i,
  input  wire adcc_cfg_t  cfg_i,
  input  wire logic       trigger_i,
  // status
  output adcc_stat_t      stat_o,
  output logic            clear_values_o
);

  //----------------------------------------------------------
  // state
  //----------------------------------------------------------
  adcc_state_t state_ff, nxt_state;     // engine state
  logic [11:0] cnt_ff, nxt_cnt;         // phase cycle counter
  adcc_stat_t  stat_ff, nxt_stat;       // status flags
  logic        clr_ff, nxt_clr;         // clear-values pulse

  // next-state logic
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_stat  = stat_ff;
    nxt_clr   = 1'b0;
    if (!run_en_i)
    begin
      // held in reset, flags drop so they describe the next run
      nxt_state = ADCC_HOLD;
      nxt_stat.foreground_complete_flag = 1'b0;
      nxt_stat.stopped = 1'b0;
    end
    else
    begin
      unique case (state_ff)
        ADCC_HOLD:
        begin
          nxt_state = ADCC_CLEAR;
          nxt_clr   = 1'b1;
        end
        ADCC_CLEAR:
        begin
          // stored values were wiped, now run or skip foreground
          if (cfg_i.foreground_cal_enable)
          begin
            nxt_state = ADCC_FG_LIN;
            nxt_cnt   = adcc_phase_len(cfg_i.linearity_averaging_level);
          end
          else
          begin
            nxt_state = cfg_i.background_cal_enable ? ADCC_BG_RUN : ADCC_DONE;
            nxt_stat.foreground_complete_flag = 1'b1;
            nxt_stat.stopped = !cfg_i.background_cal_enable;
          end
        end
        ADCC_FG_LIN:
        begin
          if (cnt_ff != 12'h000)
            nxt_cnt = cnt_ff - 12'h001;
          else if (cfg_i.fg_offset_cal_enable)
          begin
            // offset pass only exists inside a foreground run
            nxt_state = ADCC_FG_OFS;
            nxt_cnt   = adcc_phase_len(cfg_i.offset_averaging_level);
          end
          else
          begin
            nxt_state = cfg_i.background_cal_enable ? ADCC_BG_RUN : ADCC_DONE;
            nxt_stat.foreground_complete_flag = 1'b1;
            nxt_stat.stopped = !cfg_i.background_cal_enable;
          end
        end
        ADCC_FG_OFS:
        begin
          if (cnt_ff != 12'h000)
            nxt_cnt = cnt_ff - 12'h001;
          else
          begin
            nxt_state = cfg_i.background_cal_enable ? ADCC_BG_RUN : ADCC_DONE;
            nxt_stat.foreground_complete_flag = 1'b1;
            nxt_stat.stopped = !cfg_i.background_cal_enable;
          end
        end
        ADCC_BG_RUN:
        begin
          // a low trigger asks background calibration to halt
          if (!trigger_i)
          begin
            nxt_state = ADCC_BG_STOP;
            nxt_stat.stopped = 1'b1;
          end
        end
        ADCC_BG_STOP:
        begin
          if (trigger_i)
          begin
            nxt_state = ADCC_BG_RUN;
            nxt_stat.stopped = 1'b0;
          end
        end
        ADCC_DONE:
          nxt_state = ADCC_DONE;
        default:
          nxt_state = ADCC_HOLD;
      endcase
    end
    nxt_stat.code = nxt_state;
  end

  // state registers
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_ff <= ADCC_HOLD;
      cnt_ff   <= 12'h000;
      stat_ff  <= '0;
      clr_ff   <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      stat_ff  <= nxt_stat;
      clr_ff   <= nxt_clr;
    end
  end

  assign stat_o         = stat_ff;
  assign clear_values_o = clr_ff;

endmodule : adcc_cal_seq

// *** hdl/adcc_regs.sv ***
`timescale 1ns/1ps
`include "adcc_params.svh"

module adcc_regs
  import adcc_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // register port
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic [7:0]      rd_data_o,
  // device pins and neighbours
  input  wire logic       trigger_input_pin_i,
  input  wire logic       alarm_i,
  input  wire logic       serial_link_output_enable_i,
  output logic            status_output_pin_o,
  // calibration engine controls
  output logic            cal_logic_reset_o,
  output logic            divider_reset_o,
  output adcc_cfg_t       cal_cfg_o,
  output logic            clear_values_o,
  output adcc_stat_t      cal_stat_o
);

  //----------------------------------------------------------
  // register storage
  //----------------------------------------------------------
  // full bytes are kept so reserved bits read back as written
  logic [7:0] run_en_ff,  nxt_run_en;   // run enable register
  logic [7:0] mode_ff,    nxt_mode;     // mode configuration
  logic [7:0] idle_ff,    nxt_idle;     // idle core configuration
  logic [7:0] avg_ff,     nxt_avg;      // averaging depths
  logic [7:0] pin_ff,     nxt_pin;      // status pin and trigger source
  logic [7:0] soft_ff,    nxt_soft;     // software trigger
  logic [7:0] rd_ff,      nxt_rd;       // read data holding

  //----------------------------------------------------------
  // pin and output state
  //----------------------------------------------------------
  logic [2:0] trig_sync_ff, nxt_trig_sync; // pin synchroniser
  logic       trig_ff,      nxt_trig;      // filtered pin level
  logic       pin_out_ff,   nxt_pin_out;   // status pin driver
  logic       hold_ff,      nxt_hold;      // calibration reset
  logic       div_ff,       nxt_div;       // divider reset
  adcc_cfg_t  cfg_ff,       nxt_cfg;       // settings to engine

  //----------------------------------------------------------
  // internal wires
  //----------------------------------------------------------
  adcc_stat_t stat;          // engine status
  logic       trig_sel;      // selected trigger level
  logic       seq_clear;     // engine clear-values pulse
  logic [7:0] status_byte;   // status register image

  //----------------------------------------------------------
  // register writes and read data
  //----------------------------------------------------------
  // reads are answered one cycle later, zero otherwise
  always_comb
  begin
    nxt_run_en = run_en_ff;
    nxt_mode   = mode_ff;
    nxt_idle   = idle_ff;
    nxt_avg    = avg_ff;
    nxt_pin    = pin_ff;
    nxt_soft   = soft_ff;
    nxt_rd     = 8'h00;
    if (wr_i)
    begin
      unique case (addr_i)
        `ADCC_OFS_RUN_EN: nxt_run_en = wr_data_i;
        `ADCC_OFS_MODE:   nxt_mode   = wr_data_i;
        // software keeps the link off while changing this
        `ADCC_OFS_IDLE:   nxt_idle   = wr_data_i;
        `ADCC_OFS_AVG:    nxt_avg    = wr_data_i;
        `ADCC_OFS_PIN:    nxt_pin    = wr_data_i;
        `ADCC_OFS_SOFT:   nxt_soft   = wr_data_i;
        default:          nxt_run_en = run_en_ff;  // unmapped: ignored
      endcase
    end
    if (rd_i)
    begin
      unique case (addr_i)
        `ADCC_OFS_RUN_EN: nxt_rd = run_en_ff;
        `ADCC_OFS_MODE:   nxt_rd = mode_ff;
        `ADCC_OFS_IDLE:   nxt_rd = idle_ff;
        `ADCC_OFS_AVG:    nxt_rd = avg_ff;
        `ADCC_OFS_STATUS: nxt_rd = status_byte;
        `ADCC_OFS_PIN:    nxt_rd = pin_ff;
        `ADCC_OFS_SOFT:   nxt_rd = soft_ff;
        default:          nxt_rd = 8'h00;  // unmapped reads zero
      endcase
    end
  end

  // register file flops
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      run_en_ff <= `ADCC_RST_RUN_EN;
      mode_ff   <= `ADCC_RST_MODE;
      idle_ff   <= `ADCC_RST_IDLE;
      avg_ff    <= `ADCC_RST_AVG;
      pin_ff    <= `ADCC_RST_PIN;
      soft_ff   <= `ADCC_RST_SOFT;
      rd_ff     <= 8'h00;
    end
    else
    begin
      run_en_ff <= nxt_run_en;
      mode_ff   <= nxt_mode;
      idle_ff   <= nxt_idle;
      avg_ff    <= nxt_avg;
      pin_ff    <= nxt_pin;
      soft_ff   <= nxt_soft;
      rd_ff     <= nxt_rd;
    end
  end

  //----------------------------------------------------------
  // status register image
  //----------------------------------------------------------
  // reserved bits 7:5 read zero
  always_comb
  begin
    status_byte = 8'h00;
    status_byte[`ADCC_STAT_HI:`ADCC_STAT_LO] = stat.code;
    status_byte[`ADCC_STOP_BIT] = stat.stopped;
    status_byte[`ADCC_DONE_BIT] = stat.foreground_complete_flag;
  end

  //----------------------------------------------------------
  // trigger pin synchroniser and source select
  //----------------------------------------------------------
  // the pin is asynchronous; a level counts only once stages
  // two and three agree, so one-cycle glitches are dropped
  always_comb
  begin
    nxt_trig_sync = {trig_sync_ff[1:0], trigger_input_pin_i};
    nxt_trig      = trig_ff;
    if (trig_sync_ff[1] == trig_sync_ff[2])
      nxt_trig = trig_sync_ff[2];
  end

  // synchroniser flops; pin assumed low at reset
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      trig_sync_ff <= 3'h0;
      trig_ff      <= 1'b0;
    end
    else
    begin
      trig_sync_ff <= nxt_trig_sync;
      trig_ff      <= nxt_trig;
    end
  end

  // source 0 takes the register and ignores the pin
  assign trig_sel = pin_ff[`ADCC_TRIGSRC_BIT] ? trig_ff : soft_ff[`ADCC_SOFT_BIT];

  //----------------------------------------------------------
  // engine controls and status pin
  //----------------------------------------------------------
  always_comb
  begin
    // calibration logic and dividers held while enable is low;
    // software must have dropped the serial link before this
    nxt_hold = !run_en_ff[`ADCC_RUN_EN_BIT];
    nxt_div  = !run_en_ff[`ADCC_RUN_EN_BIT];
    nxt_cfg.foreground_cal_enable = mode_ff[`ADCC_FG_BIT];
    nxt_cfg.background_cal_enable = mode_ff[`ADCC_BG_BIT];
    // offset modes are gated by their parent mode
    nxt_cfg.bg_offset_cal_enable =
      mode_ff[`ADCC_BGOS_BIT] & mode_ff[`ADCC_BG_BIT];
    nxt_cfg.fg_offset_cal_enable =
      mode_ff[`ADCC_FGOS_BIT] & mode_ff[`ADCC_FG_BIT];
    nxt_cfg.idle_core = idle_ff[`ADCC_IDLE_HI:`ADCC_IDLE_LO];
    // reserved code idles nothing; background needs all cores
    nxt_cfg.idle_active = !mode_ff[`ADCC_BG_BIT] &&
      (idle_ff[`ADCC_IDLE_HI:`ADCC_IDLE_LO] != `ADCC_IDLE_RSVD);
    nxt_cfg.offset_averaging_level = avg_ff[`ADCC_OSAVG_HI:`ADCC_OSAVG_LO];
    nxt_cfg.linearity_averaging_level = avg_ff[`ADCC_LINAVG_HI:`ADCC_LINAVG_LO];
    unique case (pin_ff[`ADCC_PINSEL_HI:`ADCC_PINSEL_LO])
      `ADCC_PSEL_DONE:  nxt_pin_out = stat.foreground_complete_flag;
      `ADCC_PSEL_STOP:  nxt_pin_out = stat.stopped;
      `ADCC_PSEL_ALARM: nxt_pin_out = alarm_i;
      `ADCC_PSEL_LOW:   nxt_pin_out = 1'b0;
    endcase
  end

  // control output flops; reset holds engine and dividers, zeroes settings and pin
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hold_ff    <= 1'b1;
      div_ff     <= 1'b1;
      cfg_ff     <= '0;
      pin_out_ff <= 1'b0;
    end
    else
    begin
      hold_ff    <= nxt_hold;
      div_ff     <= nxt_div;
      cfg_ff     <= nxt_cfg;
      pin_out_ff <= nxt_pin_out;
    end
  end

  //----------------------------------------------------------
  // calibration sequencer
  //----------------------------------------------------------
  // the engine sees registered settings, one cycle behind the
  // register file; harmless since software parks it first
  adcc_cal_seq u_seq (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .run_en_i       (!hold_ff),
    .cfg_i          (cfg_ff),
    .trigger_i      (trig_sel),
    .stat_o         (stat),
    .clear_values_o (seq_clear)
  );

  //----------------------------------------------------------
  // outputs
  //----------------------------------------------------------
  assign rd_data_o           = rd_ff;
  assign status_output_pin_o = pin_out_ff;
  assign cal_logic_reset_o   = hold_ff;
  assign divider_reset_o     = div_ff;
  assign cal_cfg_o           = cfg_ff;
  assign clear_values_o      = seq_clear;
  assign cal_stat_o          = stat;

  // link enable is watched by software ordering only
  logic link_unused;
  assign link_unused = serial_link_output_enable_i;

endmodule : adcc_regs

// *** test/adcc_regs_chk.sv ***
`timescale 1ns/1ps
//--------------------
// register block checker
//--------------------
module adcc_regs_chk
  import adcc_pkg::*;
(
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rd_data_o,
  // engine side
  input wire logic       cal_logic_reset_o,
  input wire logic       divider_reset_o,
  input wire adcc_cfg_t  cal_cfg_o,
  input wire logic       clear_values_o,
  input wire adcc_stat_t cal_stat_o
);
  // one domain, so one clock and one disable for all
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  hold_div_same_a: assert property (cal_logic_reset_o == divider_reset_o)
    else $error("divider reset differs from hold");
  run_off_hold_a: assert property (wr_i && addr_i == 8'h61 && !wr_data_i[0] |-> ##2 cal_logic_reset_o)
    else $error("hold missing after run enable cleared");
  run_on_go_a: assert property (wr_i && addr_i == 8'h61 && wr_data_i[0] |-> ##2 !cal_logic_reset_o)
    else $error("hold stuck after run enable set");
  start_wipe_a: assert property ($fell(cal_logic_reset_o) |-> ##1 clear_values_o)
    else $error("no value wipe at calibration start");
  hold_clears_a: assert property (cal_logic_reset_o |=> !cal_stat_o.foreground_complete_flag)
    else $error("done flag kept during hold");
  fg_os_gate_a: assert property (cal_cfg_o.fg_offset_cal_enable |-> cal_cfg_o.foreground_cal_enable)
    else $error("foreground offset without foreground");
  bg_os_gate_a: assert property (cal_cfg_o.bg_offset_cal_enable |-> cal_cfg_o.background_cal_enable)
    else $error("background offset without background");
  idle_gate_a: assert property (cal_cfg_o.idle_active |-> !cal_cfg_o.background_cal_enable
    && cal_cfg_o.idle_core != 2'h3)
    else $error("idle core active when it must not be");
  bg_off_stop_a: assert property (cal_stat_o.foreground_complete_flag && !cal_cfg_o.background_cal_enable
    |-> cal_stat_o.stopped)
    else $error("stopped flag missing after foreground");
  stat_read_a: assert property (rd_i && addr_i == 8'h6A |=> rd_data_o == {3'h0, $past(cal_stat_o)})
    else $error("status read differs from engine status");
endmodule : adcc_regs_chk

bind adcc_regs adcc_regs_chk u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i),
  .rd_i(rd_i), .rd_data_o(rd_data_o), .cal_logic_reset_o(cal_logic_reset_o),
  .divider_reset_o(divider_reset_o), .cal_cfg_o(cal_cfg_o), .clear_values_o(clear_values_o),
  .cal_stat_o(cal_stat_o)
);

// *** test/test_adc_calibration_control.sv ***
`timescale 1ns/1ps
//--------------------
// calibration register bench
//--------------------
module test_adc_calibration_control
  import adcc_pkg::*;
;
  logic       clk_i, rst_i, wr_i, rd_i;     // clock, reset, strobes
  logic [7:0] addr_i, wr_data_i, rd_data_o; // register port
  logic       trig_pin, alarm, link_en;     // device pins
  logic       stat_pin, hold, div_rst, wipe; // observed outputs
  adcc_cfg_t  cfg;                          // effective settings
  adcc_stat_t stat;                         // engine status
  logic [7:0] mdl [0:255];                  // register model
  logic [7:0] regs [0:6] = '{8'h61, 8'h62, 8'h64, 8'h68, 8'h6B, 8'h6C, 8'h70};
  logic [7:0] v, a;                         // scratch
  int         miscompares, check_count, n, len, lin, os;
  integer     seed;

  adcc_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i),
    .rd_i(rd_i), .rd_data_o(rd_data_o), .trigger_input_pin_i(trig_pin), .alarm_i(alarm),
    .serial_link_output_enable_i(link_en), .status_output_pin_o(stat_pin), .cal_logic_reset_o(hold),
    .divider_reset_o(div_rst), .cal_cfg_o(cfg), .clear_values_o(wipe), .cal_stat_o(stat));

  // 20 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  //--------------------
  // helpers
  //--------------------
  task check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // one-cycle write; model keeps only mapped writable bytes
  task wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk_i);
    addr_i    <= ad;
    wr_data_i <= d;
    wr_i      <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    if (ad inside {8'h61, 8'h62, 8'h64, 8'h68, 8'h6B, 8'h6C})
      mdl[ad] = d;
  endtask : wr

  // data stand only in the cycle after the strobe
  task rd(input logic [7:0] ad, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= ad;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rd_data_o;
  endtask : rd

  task chk_reg(input logic [7:0] ad);
    rd(ad, v);
    check(v, mdl[ad]);
  endtask : chk_reg

  // bounded wait on done (b=0) or stopped (b=1)
  task wait_for(input int b, input logic val, input int lim, output int cnt);
    cnt = 0;
    while ((b == 0 ? stat.foreground_complete_flag : stat.stopped) !== val)
    begin
      @(posedge clk_i);
      #1 cnt++;
      if (cnt > lim)
      begin
        miscompares++;
        $display("ERROR %0t wait expired", $time);
        wrap_up();
      end
    end
  endtask : wait_for

  // settings as the rules derive them from the model
  function automatic adcc_cfg_t exp_cfg();
    adcc_cfg_t c;
    c.foreground_cal_enable     = mdl[8'h62][0];
    c.background_cal_enable     = mdl[8'h62][1];
    c.fg_offset_cal_enable      = mdl[8'h62][2] & mdl[8'h62][0];
    c.bg_offset_cal_enable      = mdl[8'h62][3] & mdl[8'h62][1];
    c.idle_core                 = mdl[8'h64][1:0];
    c.idle_active               = !mdl[8'h62][1] && mdl[8'h64][1:0] != 2'h3;
    c.offset_averaging_level    = mdl[8'h68][6:4];
    c.linearity_averaging_level = mdl[8'h68][2:0];
    return c;
  endfunction : exp_cfg

  //--------------------
  // main sequence
  //--------------------
  initial
  begin
    seed = 68206;
    {rst_i, wr_i, rd_i, addr_i, wr_data_i} = {1'b1, 18'h0};
    {trig_pin, alarm, link_en, miscompares, check_count} = '0;
    for (int i = 0; i < 256; i++)
      mdl[i] = 8'h00;
    {mdl[8'h61], mdl[8'h62], mdl[8'h64], mdl[8'h68], mdl[8'h6C]} = 40'h01_01_01_61_01;
    repeat (6) @(posedge clk_i);
    check({hold, div_rst}, 2'h3);
    rst_i <= 1'b0;
    // reset values, unmapped byte reads zero
    for (int i = 0; i < 7; i++)
      chk_reg(regs[i]);
    // default run: foreground only, background off
    wait_for(0, 1'b1, 1000, n);
    check(stat.stopped, 1'b1);
    rd(8'h6A, v);
    check(v, 8'h1B);
    link_en <= 1'b1;
    // status pin selector against alarm levels
    for (int s = 0; s < 4; s++)
      for (int k = 0; k < 2; k++)
      begin
        alarm <= k[0];
        wr(8'h6B, 8'(s << 1));
        repeat (3) @(posedge clk_i);
        #1 check(stat_pin, s < 2 ? 1'b1 : (s == 2 ? k[0] : 1'b0));
      end
    // link off before hold, then hold with reserved bits set
    link_en <= 1'b0;
    wr(8'h61, 8'hFE);
    repeat (3) @(posedge clk_i);
    #1 check({hold, div_rst, stat}, 7'h60);
    chk_reg(8'h61);
    wr(8'h6A, 8'hFF);
    rd(8'h6A, v);
    check(v, 8'h00);
    wr(8'h70, 8'h55);
    chk_reg(8'h70);
    // random settings while held
    for (int i = 0; i < 12; i++)
    begin
      a = regs[1 + {$random(seed)} % 5];
      wr(a, 8'($random(seed)));
      chk_reg(a);
      check(cfg, exp_cfg());
    end
    // foreground phase lengths follow averaging depths
    wr(8'h6B, 8'h00);
    wr(8'h6C, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      lin = {$random(seed)} % 3;
      os  = {$random(seed)} % 3;
      wr(8'h61, 8'h00);
      wr(8'h68, 8'((os << 4) | lin));
      wr(8'h62, i[0] ? 8'h05 : 8'h01);
      len = (16 << lin) + 1 + (i[0] ? (16 << os) + 1 : 0);
      wr(8'h61, 8'h01);
      wait_for(0, 1'b1, 1000, n);
      check(n >= len && n <= len + 10, 1'b1);
    end
    // foreground skipped
    wr(8'h61, 8'h00);
    wr(8'h62, 8'h00);
    wr(8'h61, 8'h01);
    wait_for(0, 1'b1, 20, n);
    check({stat.stopped, n <= 10}, 2'h3);
    // background with soft trigger, then pin trigger
    wr(8'h61, 8'h00);
    wr(8'h62, 8'h0B);
    wr(8'h61, 8'h01);
    wait_for(0, 1'b1, 1000, n);
    wait_for(1, 1'b0, 10, n);
    check({cfg.bg_offset_cal_enable, cfg.idle_active}, 2'h2);
    wr(8'h6C, 8'h00);
    wait_for(1, 1'b1, 10, n);
    check(stat.stopped, 1'b1);
    wr(8'h6C, 8'h01);
    wait_for(1, 1'b0, 10, n);
    check(stat.stopped, 1'b0);
    trig_pin <= 1'b1;
    wr(8'h6B, 8'h01);
    wr(8'h6C, 8'h00);
    repeat (8) @(posedge clk_i);
    #1 check(stat.stopped, 1'b0);
    trig_pin <= 1'b0;
    wait_for(1, 1'b1, 12, n);
    check(stat.stopped, 1'b1);
    wrap_up();
  end
endmodule : test_adc_calibration_control
